//--- inc/pgt_pkg.sv
// Constants, types and field layout of the power-good tree mask block
// Contract
// - Pin one mask A: rail two, A1, steps
// - Pin one mask B high: control inputs 5,4,2,1
// - Pin one mask B low: termination, shared, B1, LDO3
// - Shared bit follows factory rail selection
// - Pin four mask A mirrors pin one A
// - Set mask bit excludes source from tree
// - Eight-bit RW masks, factory reset values
`default_nettype none

package pgt_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] PGT_OFS_ONE_A  = 8'hA4;
    localparam logic [7:0] PGT_OFS_ONE_B  = 8'hA5;
    localparam logic [7:0] PGT_OFS_FOUR_A = 8'hA6;

    // ---------------------------------------------------------------
    // Field positions, mask A
    // ---------------------------------------------------------------
    localparam int PGT_A_LDO2_BIT  = 7;
    localparam int PGT_A_LOAD_SWITCH_A_ONE_BIT  = 6;
    localparam int PGT_A_STEP6_BIT = 5;
    localparam int PGT_A_STEP1_BIT = 0;

    // ---------------------------------------------------------------
    // Field positions, mask B
    // ---------------------------------------------------------------
    localparam int PGT_B_CONTROL_INPUT_5_BIT   = 7;
    localparam int PGT_B_CONTROL_INPUT_4_BIT   = 6;
    localparam int PGT_B_CONTROL_INPUT_2_BIT   = 5;
    localparam int PGT_B_CONTROL_INPUT_1_BIT   = 4;
    localparam int PGT_B_TERM_BIT   = 3;
    localparam int PGT_B_SHARED_BIT = 2;
    localparam int PGT_B_LOAD_SWITCH_B_ONE_BIT   = 1;
    localparam int PGT_B_LDO3_BIT   = 0;

    // ---------------------------------------------------------------
    // Reset values of the shown factory variant
    // ---------------------------------------------------------------
    localparam logic [7:0] PGT_RST_ONE_A  = 8'h00;
    localparam logic [7:0] PGT_RST_ONE_B  = 8'h00;
    localparam logic [7:0] PGT_RST_FOUR_A = 8'h00;

    typedef logic [7:0] pgt_byte_t;

endpackage

`default_nettype wire

//--- hw/pgt_tree.sv
// One power-good tree: masked AND of sixteen sources
`default_nettype none

module pgt_tree
    import pgt_pkg::*;
(
    // Sources and masks
    input  wire logic [15:0] src_good,
    input  wire logic [15:0] src_mask,
    // Result
    output logic             tree_good
);

    logic [15:0] term;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_term
            assign term[gi] = src_good[gi] | src_mask[gi];
        end
    endgenerate

    assign tree_good = &term;

endmodule

`default_nettype wire

//--- hw/pgt_mask_top.sv
// Power-good tree mask registers and pin one / pin four outputs
`default_nettype none

module pgt_mask_top
    import pgt_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Factory configuration, sampled in any cycle with factory_load high
    input  wire logic [7:0] factory_one_a,
    input  wire logic [7:0] factory_one_b,
    input  wire logic [7:0] factory_four_a,
    input  wire logic       factory_shared_is_ldo,
    input  wire logic       factory_load,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // Rail power-good inputs
    input  wire logic       low_dropout_rail_two,
    input  wire logic       load_switch_a_one,
    input  wire logic [5:0] stepdown_rail,
    input  wire logic       termination_regulator,
    input  wire logic       load_switch_b_two_good,
    input  wire logic       low_dropout_rail_one_good,
    input  wire logic       load_switch_b_one,
    input  wire logic       low_dropout_rail_three,
    // Control input status
    input  wire logic       control_input_1,
    input  wire logic       control_input_2,
    input  wire logic       control_input_4,
    input  wire logic       control_input_5,
    // Power-good pins
    output logic            pg_output_pin_one,
    output logic            pg_output_pin_four
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        pgt_byte_t one_a;
        pgt_byte_t one_b;
        pgt_byte_t four_a;
        logic      shared_ldo;
        pgt_byte_t rdata;
        logic      pin_one;
        logic      pin_four;
    } pgt_state_s;

    pgt_state_s st_r;
    pgt_state_s st_nxt;

    logic        shared_good;
    logic [7:0]  grp_a;
    logic [7:0]  grp_b;
    logic        good_one;
    logic        good_four;

    // ---------------------------------------------------------------
    // Source groups
    // ---------------------------------------------------------------
    // Shared bit tracks factory rail choice
    assign shared_good = st_r.shared_ldo ? low_dropout_rail_one_good
                                         : load_switch_b_two_good;

    assign grp_a = {low_dropout_rail_two, load_switch_a_one, stepdown_rail};

    // Control inputs in mask B high half, rails in low half
    assign grp_b = {control_input_5, control_input_4, control_input_2,
                    control_input_1, termination_regulator, shared_good,
                    load_switch_b_one, low_dropout_rail_three};

    pgt_tree u_tree_one (
        .src_good  ({grp_b, grp_a}),
        .src_mask  ({st_r.one_b, st_r.one_a}),
        .tree_good (good_one)
    );

    // Pin four second mask lies outside this block; it stays all-included
    // Same mapping as pin one
    pgt_tree u_tree_four (
        .src_good  ({grp_b, grp_a}),
        .src_mask  ({8'h00, st_r.four_a}),
        .tree_good (good_four)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (factory_load) begin
            st_nxt.one_a      = factory_one_a;
            st_nxt.one_b      = factory_one_b;
            st_nxt.four_a     = factory_four_a;
            st_nxt.shared_ldo = factory_shared_is_ldo;
        end else if (reg_wr) begin
            if (reg_addr == PGT_OFS_ONE_A) begin
                st_nxt.one_a = reg_wdata;
            end else if (reg_addr == PGT_OFS_ONE_B) begin
                st_nxt.one_b = reg_wdata;
            end else if (reg_addr == PGT_OFS_FOUR_A) begin
                st_nxt.four_a = reg_wdata;
            end
        end
        // Unmapped reads return zero
        if (reg_addr == PGT_OFS_ONE_A) begin
            st_nxt.rdata = st_r.one_a;
        end else if (reg_addr == PGT_OFS_ONE_B) begin
            st_nxt.rdata = st_r.one_b;
        end else if (reg_addr == PGT_OFS_FOUR_A) begin
            st_nxt.rdata = st_r.four_a;
        end else begin
            st_nxt.rdata = 8'h00;
        end
        st_nxt.pin_one  = good_one;
        st_nxt.pin_four = good_four;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r.one_a      <= PGT_RST_ONE_A;
            st_r.one_b      <= PGT_RST_ONE_B;
            st_r.four_a     <= PGT_RST_FOUR_A;
            st_r.shared_ldo <= 1'b0;
            st_r.rdata      <= 8'h00;
            st_r.pin_one    <= 1'b0;
            st_r.pin_four   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata          = st_r.rdata;
    assign pg_output_pin_one  = st_r.pin_one;
    assign pg_output_pin_four = st_r.pin_four;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_write_one_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && !factory_load && reg_addr == PGT_OFS_ONE_A)
        ##1 (reg_addr == PGT_OFS_ONE_A) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("mask A of pin one not written");

    a_factory_load: assert property (@(posedge core_clk) disable iff (rst)
        factory_load |=> st_r.four_a == $past(factory_four_a))
        else $error("factory value not loaded");

    a_masked_rail: assert property (@(posedge core_clk) disable iff (rst)
        (st_r.one_a == 8'hFF && st_r.one_b == 8'hFF) |=> pg_output_pin_one)
        else $error("fully masked pin one not good");

    a_rail_bad: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.one_a[PGT_A_LDO2_BIT] && !low_dropout_rail_two) |=> !pg_output_pin_one)
        else $error("included bad rail left pin one good");

    a_ctl_bad: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.one_b[PGT_B_CONTROL_INPUT_5_BIT] && !control_input_5) |=> !pg_output_pin_one)
        else $error("included control input low left pin one good");

    a_term_bad: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.one_b[PGT_B_TERM_BIT] && !termination_regulator) |=> !pg_output_pin_one)
        else $error("included termination rail bad left pin one good");

    a_shared_sel: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.one_b[PGT_B_SHARED_BIT] && st_r.shared_ldo && !low_dropout_rail_one_good)
        |=> !pg_output_pin_one)
        else $error("shared bit ignored selected rail");

    a_four_step: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.four_a[PGT_A_STEP1_BIT] && !stepdown_rail[0]) |=> !pg_output_pin_four)
        else $error("pin four ignored included step-down rail");

    a_write_one_b: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && !factory_load && reg_addr == PGT_OFS_ONE_B)
        ##1 (reg_addr == PGT_OFS_ONE_B) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("mask B of pin one not written");

    a_write_four_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && !factory_load && reg_addr == PGT_OFS_FOUR_A)
        ##1 (reg_addr == PGT_OFS_FOUR_A) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("mask A of pin four not written");

    a_load_wins: assert property (@(posedge core_clk) disable iff (rst)
        (factory_load && reg_wr && reg_addr == PGT_OFS_ONE_A)
        |=> st_r.one_a == $past(factory_one_a))
        else $error("write beat factory load");

    a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
        (reg_addr != PGT_OFS_ONE_A && reg_addr != PGT_OFS_ONE_B
         && reg_addr != PGT_OFS_FOUR_A)
        |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_pin_one_good: assert property (@(posedge core_clk) disable iff (rst)
        ((&(grp_a | st_r.one_a)) && (&(grp_b | st_r.one_b))) |=> pg_output_pin_one)
        else $error("pin one low with all included sources good");

    a_shared_b2: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.one_b[PGT_B_SHARED_BIT] && !st_r.shared_ldo && !load_switch_b_two_good)
        |=> !pg_output_pin_one)
        else $error("shared bit ignored switch B2 rail");

    a_step_six: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.one_a[PGT_A_STEP6_BIT] && !stepdown_rail[5]) |=> !pg_output_pin_one)
        else $error("included step-down rail six left pin one good");

    a_four_rail_two: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.four_a[PGT_A_LDO2_BIT] && !low_dropout_rail_two) |=> !pg_output_pin_four)
        else $error("pin four ignored included rail two");

    a_four_masked: assert property (@(posedge core_clk) disable iff (rst)
        (st_r.four_a == 8'hFF && (&grp_b)) |=> pg_output_pin_four)
        else $error("fully masked pin four not good");

endmodule

`default_nettype wire

//--- sim/pgt_sys_model.sv
// Model of the system rails and control inputs around the power-good pins
`default_nettype none

module pgt_sys_model (
    // Clock and requested rail levels
    input  wire logic        core_clk,
    input  wire logic [16:0] want,
    // Rail and control levels towards the block
    output logic      [16:0] rails,
    // Power-good pins as sensed by the system
    input  wire logic        pin_one,
    input  wire logic        pin_four,
    output logic      [1:0]  seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // Levels are static between bench updates, so a plain follow is enough
    assign rails = want;

    always_ff @(posedge core_clk) begin
        seen <= {pin_four, pin_one};
    end
endmodule

`default_nettype wire

//--- sim/power_good_tree_mask_tb.sv
// Self-checking bench of the power-good tree mask block
`default_nettype none

module power_good_tree_mask_tb import pgt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        ld       = 1'b0;
    logic        sel      = 1'b0;
    logic        wr_en    = 1'b0;
    logic [7:0]  fa = 8'h00, fb = 8'h00, f4 = 8'h00, addr = 8'h00, wd = 8'h00;
    logic [7:0]  ma = 8'h00, mb = 8'h00, m4 = 8'h00;
    logic [16:0] want     = 17'h1FFFF;
    logic [31:0] lf       = 32'h103CE54C;
    wire logic [16:0] r;
    wire logic [7:0]  rd;
    wire logic        p1, p4;
    wire logic [1:0]  sn;
    int          n_fail = 0, n_compared = 0, cyc = 0;

    pgt_mask_top dut (
        .core_clk(core_clk), .rst(rst), .factory_one_a(fa), .factory_one_b(fb),
        .factory_four_a(f4), .factory_shared_is_ldo(sel), .factory_load(ld),
        .reg_addr(addr), .reg_wr(wr_en), .reg_wdata(wd), .reg_rdata(rd),
        .low_dropout_rail_two(r[15]), .load_switch_a_one(r[14]), .stepdown_rail(r[13:8]),
        .control_input_5(r[7]), .control_input_4(r[6]), .control_input_2(r[5]),
        .control_input_1(r[4]), .termination_regulator(r[3]), .load_switch_b_two_good(r[2]),
        .load_switch_b_one(r[1]), .low_dropout_rail_three(r[0]),
        .low_dropout_rail_one_good(r[16]), .pg_output_pin_one(p1), .pg_output_pin_four(p4)
    );

    pgt_sys_model sys (
        .core_clk(core_clk), .want(want), .rails(r),
        .pin_one(p1), .pin_four(p4), .seen(sn)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Bit 16 stands in for the second candidate of the shared bit
    function automatic logic exp_pg(input logic [7:0] a, b, input logic [16:0] s,
                                    input logic sh);
        logic [7:0] v;
        v = {s[7:3], sh ? s[16] : s[2], s[1:0]};
        return (&(s[15:8] | a)) & (&(v | b));
    endfunction

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(negedge core_clk);
        addr = a;
        wd = d;
        wr_en = 1'b1;
        @(negedge core_clk);
        wr_en = 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, e);
        @(negedge core_clk);
        addr = a;
        repeat (2) @(negedge core_clk);
        chk8(rd, e);
    endtask

    // Optional write in the same cycle must lose against the load
    task automatic fload(input logic [7:0] a, b, c, input logic s, w);
        @(negedge core_clk);
        {fa, fb, f4, sel, ld} = {a, b, c, s, 1'b1};
        {addr, wd, wr_en} = {PGT_OFS_ONE_A, ~a, w};
        @(negedge core_clk);
        {ld, wr_en} = 2'b00;
        {ma, mb, m4} = {a, b, c};
    endtask

    task automatic pins(input logic [16:0] s);
        logic e1, e4;
        e1 = exp_pg(ma, mb, s, sel);
        e4 = exp_pg(m4, 8'h00, s, sel);
        @(negedge core_clk);
        want = s;
        @(negedge core_clk);
        chk_pin(p1, e1);
        chk_pin(p4, e4);
        // System side sees the pins one register later
        @(negedge core_clk);
        chk_pin(sn[0], e1);
        chk_pin(sn[1], e4);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        rdc(PGT_OFS_ONE_A, PGT_RST_ONE_A);
        rdc(PGT_OFS_ONE_B, PGT_RST_ONE_B);
        rdc(PGT_OFS_FOUR_A, PGT_RST_FOUR_A);
        rdc(8'hA7, 8'h00);
        $display("test reset values done");
        fload(8'hFF, 8'hFF, 8'hFF, 1'b1, 1'b1);
        rdc(PGT_OFS_ONE_A, 8'hFF);
        pins(17'h00000);
        pins(17'h100FF);
        $display("test all masked done");
        // Both shared selections, each candidate rail failing alone
        for (int j = 0; j < 2; j++) begin
            fload(8'h00, 8'h00, 8'h00, j[0], 1'b0);
            pins(~17'h00004);
            pins(~17'h10000);
            pins(17'h00000);
        end
        $display("test shared select done");
        for (int i = 0; i < 200; i++) begin
            lf = nxt(lf);
            if (i % 2 == 0) begin
                fload(lf[7:0], lf[15:8], lf[23:16], lf[24], lf[25]);
            end else begin
                wr(PGT_OFS_ONE_A, lf[7:0]);
                wr(PGT_OFS_ONE_B, lf[15:8]);
                wr(PGT_OFS_FOUR_A, lf[23:16]);
                wr(8'hA7, ~lf[7:0]);
                {m4, mb, ma} = lf[23:0];
            end
            rdc(PGT_OFS_ONE_A, ma);
            rdc(PGT_OFS_ONE_B, mb);
            rdc(PGT_OFS_FOUR_A, m4);
            pins((i % 3 == 0) ? lf[31:15] : ~(17'h00001 << (i % 17)));
        end
        $display("test random masks done");
        // Mid-run reset: loaded masks and shared select fall back
        @(negedge core_clk);
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_pin(p1, 1'b0);
        chk_pin(p4, 1'b0);
        rst = 1'b0;
        {ma, mb, m4, sel} = {PGT_RST_ONE_A, PGT_RST_ONE_B, PGT_RST_FOUR_A, 1'b0};
        rdc(PGT_OFS_ONE_A, PGT_RST_ONE_A);
        rdc(PGT_OFS_FOUR_A, PGT_RST_FOUR_A);
        pins(17'h1FFFB);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule

`default_nettype wire
